// ===== rtl/lp_exit_supervisor.sv
/*
 power-management hazard model: supervisor settle flags, subsystem clock
 overspeed after deep sleep exit, core raise reset and wake-up lockup.
 assumes an axi4-lite master on aclk; irq_in and puc_in come from pins.
*/
`include "lp_supervisor_defines.svh"
module lp_exit_supervisor #(
    parameter logic [17:0] SLOW_SETTLE_CYC = 18'(`NS_TO_CYC(`SLOW_SETTLE_NS)),
    parameter logic [17:0] CORE_RAMP_CYC = 18'(`NS_TO_CYC(`CORE_RAMP_NS))
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq_in,
    input wire logic puc_in,
    output logic subsystem_clock_fast,
    output logic cpu_awake,
    output logic wake_stuck,
    output logic device_reset
);
    import lp_supervisor_pkg::*;
    localparam logic [17:0] FAST_CYC = 18'(`NS_TO_CYC(`FAST_SETTLE_NS));
    localparam logic [17:0] OVER_CYC = 18'(`NS_TO_CYC(`OVERSPEED_NS));
    localparam logic [17:0] WAKE_CYC = 18'(`NS_TO_CYC(`WAKE_WINDOW_NS));
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] low_ctl;
        logic [7:0] high_ctl;
        logic [1:0] clk_ctl;
        power_mode_e mode;
        count_t over_cnt;
        count_t entry_cnt;
        logic hazard;
        count_t ramp_cnt;
        logic stuck;
        logic rst_pulse;
        logic [1:0] irq_sync;
        logic [1:0] puc_sync;
    } st_s;
    st_s s_r, s_nxt;
    logic low_flag, high_flag, low_wr, high_wr, fast_wake;
    logic wr_fire, deep, sleepy;
    logic [7:0] wb;
    always_comb begin
        wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
        low_wr = wr_fire && s_r.waddr == `OFS_LOW_CTL;
        high_wr = wr_fire && s_r.waddr == `OFS_HIGH_CTL;
    end
    settle_timer #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_SETTLE_CYC)) u_low (
        .aclk(aclk), .aresetn(aresetn), .start(low_wr),
        .full_perf(s_nxt.low_ctl[`LOW_FP_BIT]), .flag(low_flag));
    settle_timer #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_SETTLE_CYC)) u_high (
        .aclk(aclk), .aresetn(aresetn), .start(high_wr),
        .full_perf(1'b0), .flag(high_flag));
    always_comb begin
        s_nxt = s_r;
        wb = s_r.wstrb[0] ? s_r.wdata[7:0] : 8'h00;
        deep = 1'b0;
        sleepy = s_r.mode == MODE_SLEEP_TWO || s_r.mode == MODE_DEEP_THREE
            || s_r.mode == MODE_DEEP_FOUR;
        // low side fast wake-up or switched off
        fast_wake = !s_r.low_ctl[`LOW_EN_BIT] || s_r.low_ctl[`LOW_FP_BIT]
            || !s_r.low_ctl[`LOW_MON_EN_BIT] || s_r.low_ctl[`LOW_MON_FP_BIT]; // [R12]
        s_nxt.rst_pulse = 1'b0;
        s_nxt.irq_sync = {s_r.irq_sync[0], irq_in};
        s_nxt.puc_sync = {s_r.puc_sync[0], puc_in};
        if (s_axi_awvalid && !s_r.aw_got) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_got) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (wr_fire) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = 2'b00;
            unique case (s_r.waddr)
                `OFS_LOW_CTL: if (s_r.wstrb[0]) s_nxt.low_ctl = wb;
                `OFS_HIGH_CTL: if (s_r.wstrb[0]) s_nxt.high_ctl = wb;
                `OFS_CLK_CTL: if (s_r.wstrb[0]) s_nxt.clk_ctl = wb[1:0];
                `OFS_MODE: if (s_r.wstrb[0] && !s_r.stuck && wb[2:0] <= 3'd5) begin
                    s_nxt.mode = power_mode_e'(wb[2:0]);
                end
                `OFS_FLAGS, `OFS_STATUS: ;
                default: s_nxt.bresp = 2'b10;
            endcase
            if (s_r.waddr == `OFS_LOW_CTL && s_r.wstrb[0]
                && wb[`CORE_LVL_HI:`CORE_LVL_LO] > s_r.low_ctl[`CORE_LVL_HI:`CORE_LVL_LO]) begin
                s_nxt.ramp_cnt = CORE_RAMP_CYC;
            end
            if (s_r.waddr == `OFS_MODE && s_r.wstrb[0] && !s_r.stuck
                && wb[2:0] >= 3'd3 && wb[2:0] <= 3'd5) begin
                s_nxt.entry_cnt = WAKE_CYC;
                s_nxt.hazard = (low_flag || high_flag || low_wr || high_wr) && fast_wake; // [R11]
            end
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
        end
        if (s_axi_arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = 2'b00;
            unique case (s_axi_araddr)
                `OFS_LOW_CTL: s_nxt.rdata = {24'h0, s_r.low_ctl};
                `OFS_HIGH_CTL: s_nxt.rdata = {24'h0, s_r.high_ctl};
                `OFS_FLAGS: s_nxt.rdata = {30'h0, high_flag, low_flag};
                `OFS_CLK_CTL: s_nxt.rdata = {30'h0, s_r.clk_ctl};
                `OFS_MODE: s_nxt.rdata = {29'h0, s_r.mode};
                `OFS_STATUS: s_nxt.rdata = {29'h0, s_r.rst_pulse, s_r.stuck,
                    s_r.over_cnt != '0};
                default: begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.rresp = 2'b10;
                end
            endcase
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_r.entry_cnt != '0) begin
            s_nxt.entry_cnt = s_r.entry_cnt - 18'd1;
        end
        if (s_r.ramp_cnt != '0) begin
            s_nxt.ramp_cnt = s_r.ramp_cnt - 18'd1;
        end
        if (s_r.over_cnt != '0) begin
            s_nxt.over_cnt = s_r.over_cnt - 18'd1;
        end
        // supervisor settle ends mid-ramp in full performance
        if (s_r.ramp_cnt != '0 && s_r.low_ctl[`LOW_FP_BIT] && !low_flag
            && s_r.low_ctl[`LOW_EN_BIT]) begin
            s_nxt.rst_pulse = 1'b1; // [R07]
            s_nxt.ramp_cnt = '0;
            s_nxt.mode = MODE_ACTIVE;
        end
        if (sleepy && s_r.irq_sync[1] && !s_r.stuck) begin
            if (s_r.entry_cnt != '0 && s_r.hazard) begin
                s_nxt.stuck = 1'b1; // [R09]
            end else begin
                deep = s_r.mode == MODE_DEEP_THREE || s_r.mode == MODE_DEEP_FOUR;
                s_nxt.mode = MODE_ACTIVE;
                if (deep && !s_r.clk_ctl[`CLK_SRC_XT2_BIT]) begin
                    s_nxt.over_cnt = OVER_CYC; // [R01]
                end
            end
        end
        if (s_r.puc_sync[1] || s_nxt.rst_pulse) begin
            s_nxt.stuck = 1'b0; // [R10]
            s_nxt.mode = MODE_ACTIVE;
            s_nxt.hazard = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.low_ctl <= `LOW_CTL_RST;
            s_r.high_ctl <= `HIGH_CTL_RST;
            s_r.mode <= MODE_ACTIVE; // [R10]
        end else begin
            s_r <= s_nxt;
        end
    end
    assign s_axi_awready = !s_r.aw_got;
    assign s_axi_wready = !s_r.w_got;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign subsystem_clock_fast = s_r.over_cnt != '0;
    assign cpu_awake = s_r.mode == MODE_ACTIVE;
    assign wake_stuck = s_r.stuck;
    assign device_reset = s_r.rst_pulse;
endmodule

// ===== pkg/lp_supervisor_defines.svh
/*
 constants for the low-power exit supervisor model: register offsets,
 field positions, reset values and timing counts.
 assumes a 100 mhz aclk and an axi4-lite register bus.
*/
// Function
// R01: on exit from deep sleep three or four with the subsystem clock on the tunable oscillator, the clock is not masked and runs fast for up to 6 us.
// R02: choosing the second crystal oscillator as subsystem clock source avoids the overspeed.
// R03: with the request enable kept set, firmware halts subsystem-clock modules before deep sleep.
// R04: after wake-up firmware waits 32, 48, 64 or 80 cycles per core level before re-enabling sensitive modules.
// R05: with low-side full performance set, the supervisor settling delay is about 2 us.
// R06: with low-side full performance clear, the settling delay is about 150 us.
// R07: raising the core level in full performance lets the delay end before the ramp finishes, and the device resets.
// R08: firmware sets normal mode before raising the core level.
// R09: an interrupt within 1 us of sleep two, three or four entry may leave the device not waking.
// R10: the stuck state clears on external reset, power cycle or power-up clear.
// R11: the failure needs a supervisor control write followed by entry before both settle flags are zero.
// R12: the failure also needs the low side set for fast wake-up or switched off.
// R13: firmware waits for both settle flags to read zero before entering sleep two to four.
// R14: each settle flag sets on a write to its control register and clears when its delay elapses.
`ifndef LP_SUPERVISOR_DEFINES_SVH
`define LP_SUPERVISOR_DEFINES_SVH
`define OFS_LOW_CTL 8'h00
`define OFS_HIGH_CTL 8'h04
`define OFS_FLAGS 8'h08
`define OFS_CLK_CTL 8'h0c
`define OFS_MODE 8'h10
`define OFS_STATUS 8'h14
// low side control bits
`define LOW_EN_BIT 0
`define LOW_FP_BIT 1
`define LOW_MON_EN_BIT 2
`define LOW_MON_FP_BIT 3
`define CORE_LVL_LO 4
`define CORE_LVL_HI 5
// flags bits
`define FLAG_LOW_BIT 0
`define FLAG_HIGH_BIT 1
// clock control bits
`define CLK_SRC_XT2_BIT 0
`define CLK_REQ_EN_BIT 1
// status bits
`define ST_FAST_BIT 0
`define ST_STUCK_BIT 1
`define ST_RESET_BIT 2
`define LOW_CTL_RST 8'h01
`define HIGH_CTL_RST 8'h01
`define CLK_MHZ 100
`define FAST_SETTLE_NS 2000
`define SLOW_SETTLE_NS 150000
`define OVERSPEED_NS 6000
`define WAKE_WINDOW_NS 1000
`define CORE_RAMP_NS 50000
`define NS_TO_CYC(ns) (((ns) * `CLK_MHZ) / 1000)
`endif

// ===== pkg/lp_supervisor_pkg.sv
/*
 types for the low-power exit supervisor model.
 assumes the defines header is available.
*/
package lp_supervisor_pkg;
    typedef enum logic [2:0] {MODE_ACTIVE, MODE_LPM0, MODE_LPM1, MODE_SLEEP_TWO,
        MODE_DEEP_THREE, MODE_DEEP_FOUR} power_mode_e;
    typedef logic [17:0] count_t;
endpackage

// ===== rtl/settle_timer.sv
/*
 one supervisor settling-delay flag with its countdown.
 assumes start is a one-cycle pulse on aclk.
*/
`include "lp_supervisor_defines.svh"
module settle_timer #(
    parameter logic [17:0] FAST_CYC = 18'd200,
    parameter logic [17:0] SLOW_CYC = 18'd15000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic full_perf,
    output logic flag
);
    import lp_supervisor_pkg::*;
    typedef struct packed {
        count_t cnt;
        logic flag;
    } st_s;
    st_s s_r, s_nxt;
    always_comb begin
        s_nxt = s_r;
        if (start) begin
            s_nxt.flag = 1'b1; // [R14]
            s_nxt.cnt = full_perf ? FAST_CYC : SLOW_CYC; // [R05] [R06]
        end else if (s_r.flag) begin
            if (s_r.cnt <= 18'd1) begin
                s_nxt.flag = 1'b0; // [R14]
                s_nxt.cnt = '0;
            end else begin
                s_nxt.cnt = s_r.cnt - 18'd1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign flag = s_r.flag;
endmodule

// ===== verif/lp_exit_props.sv
/*
 checker for lp_exit_supervisor port behaviour.
 assumes binding onto the top module, single aclk domain.
*/
module lp_exit_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic puc_in,
    input wire logic subsystem_clock_fast,
    input wire logic cpu_awake,
    input wire logic wake_stuck,
    input wire logic device_reset
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [9:0] fast_cnt_r;
    always_ff @(posedge aclk) begin
        fast_cnt_r <= (!aresetn || !subsystem_clock_fast) ? 10'h0 : fast_cnt_r + 10'h1;
    end
    a_reset_pulse: assert property (device_reset |=> !device_reset)
        else $error("reset pulse too long");
    a_reset_awake: assert property (device_reset |=> cpu_awake)
        else $error("not active after reset");
    a_fast_bound: assert property (fast_cnt_r <= 10'h258)
        else $error("overspeed too long");
    a_stuck_asleep: assert property (wake_stuck |-> !cpu_awake)
        else $error("stuck yet awake");
    a_puc_recover: assert property (puc_in [*6] |-> !wake_stuck)
        else $error("stuck after clear");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    c_reset: cover property (device_reset);
    c_stuck: cover property (wake_stuck);
    c_fast: cover property ($fell(subsystem_clock_fast));
endmodule
bind lp_exit_supervisor lp_exit_props u_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .puc_in,
    .subsystem_clock_fast, .cpu_awake, .wake_stuck, .device_reset);

// ===== verif/tb_top.sv
/*
 testbench for lp_exit_supervisor: axi4-lite tasks and directed tests.
 assumes shortened slow settle 400 and core ramp 300 cycles.
*/
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic irq_in = 1'h0, puc_in = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic subsystem_clock_fast, cpu_awake, wake_stuck, device_reset;
    int num_errors = 0, n_compared = 0, i, m, fast_n = 0, base;
    lp_exit_supervisor #(.SLOW_SETTLE_CYC(18'h190), .CORE_RAMP_CYC(18'h12c)) dut_u (.aclk,
        .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq_in, .puc_in, .subsystem_clock_fast, .cpu_awake,
        .wake_stuck, .device_reset);
    initial begin
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) fast_n += subsystem_clock_fast;
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        fork
            begin
                do @(negedge aclk); while (!s_axi_awready);
                @(posedge aclk);
                s_axi_awvalid <= 1'h0;
            end
            begin
                do @(negedge aclk); while (!s_axi_wready);
                @(posedge aclk);
                s_axi_wvalid <= 1'h0;
            end
        join
        do @(negedge aclk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        @(posedge aclk) s_axi_bready <= 1'h1;
        @(posedge aclk) s_axi_bready <= 1'h0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk) s_axi_arvalid <= 1'h0;
        do @(negedge aclk); while (!s_axi_rvalid);
        v = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge aclk) s_axi_rready <= 1'h1;
        @(posedge aclk) s_axi_rready <= 1'h0;
    endtask
    task wake;
        @(posedge aclk) irq_in <= 1'h1;
        for (i = 0; i < 300 && !cpu_awake; i++) @(negedge aclk);
        @(posedge aclk) irq_in <= 1'h0;
    endtask
    task wrap_up;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge aclk);
        num_errors++;
        wrap_up;
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        rd(8'h00); chk(v, 32'h1);
        rd(8'h08); chk(v, 32'h0);
        rd(8'h40); chk(rsp, 2'h2);
        wr(8'h40, 32'h0); chk(rsp, 2'h2);
        $display("test registers done");
        wr(8'h00, 32'h3); rd(8'h08); chk(v, 32'h1);
        repeat (150) @(posedge aclk);
        rd(8'h08); chk(v, 32'h1);
        repeat (60) @(posedge aclk);
        rd(8'h08); chk(v, 32'h0);
        wr(8'h00, 32'h1); wr(8'h04, 32'h1); rd(8'h08); chk(v, 32'h3);
        repeat (350) @(posedge aclk);
        rd(8'h08); chk(v, 32'h3);
        repeat (60) @(posedge aclk);
        rd(8'h08); chk(v, 32'h0);
        $display("test settle done");
        wr(8'h00, 32'h13);
        for (i = 0; i < 400 && !device_reset; i++) @(negedge aclk);
        chk(device_reset, 1'h1);
        repeat (450) @(posedge aclk);
        wr(8'h00, 32'h21);
        for (i = 0; i < 500 && !device_reset; i++) @(negedge aclk);
        chk(device_reset, 1'h0);
        $display("test core raise done");
        for (m = 0; m < 2; m++) begin
            wr(8'h0c, m + 2);
            wr(8'h10, 32'h4);
            chk(cpu_awake, 1'h0);
            base = fast_n;
            wake;
            chk(cpu_awake, 1'h1);
            rd(8'h14);
            chk(v[0], m ? 1'h0 : 1'h1);
            repeat (700) @(posedge aclk);
            chk(fast_n - base, m ? 0 : 600);
        end
        $display("test overspeed done");
        for (m = 3; m < 6; m++) begin
            wr(8'h00, 32'h3); wr(8'h10, m);
            @(posedge aclk) irq_in <= 1'h1;
            for (i = 0; i < 150 && !wake_stuck; i++) @(negedge aclk);
            chk(wake_stuck, 1'h1);
            rd(8'h14);
            chk(v, 32'h2);
            @(posedge aclk) irq_in <= 1'h0;
            puc_in <= 1'h1;
            repeat (8) @(posedge aclk);
            puc_in <= 1'h0;
            chk(wake_stuck, 1'h0);
            wake;
        end
        wr(8'h00, 32'h5); wr(8'h10, 32'h3); wake;
        chk({wake_stuck, cpu_awake}, 2'h1);
        wr(8'h00, 32'h3);
        do begin
            rd(8'h08);
        end while (v != 32'h0);
        wr(8'h10, 32'h3);
        wake;
        chk({wake_stuck, cpu_awake}, 2'h1);
        $display("test lockup done");
        wrap_up;
    end
endmodule
